// File: hdl/eight_bit_reload_interval_timer.sv
// What this block does
// - Mode bit 0 gives an 8-bit up-counting interval timer.
// - Reset clears count to zero and mode bit, counting starts at once.
// - Count clock is one of seven prescaler taps picked by clock source field.
// - Clock at count maximum signals overflow and sets the request flag.
// - Interrupt request raised only while overflow interrupt enable is 1.
// - Interval mode wraps the count to zero on overflow.
// - Interval mode: reload write also loads the counter immediately.
// - Mode bit 1 gives auto-reload; reload write loads the counter too.
// - Auto-reload mode copies reload value into counter on overflow.
// - Auto-reload overflow period spans 1 to 256 selected clocks.
// - Counts in active and sleep, halts otherwise; mode writable only active.
`timescale 1ns/1ps
`include "reload_timer_regs.svh"

module eight_bit_reload_interval_timer
   import reload_timer_pkg::*;
(
   input wire logic core_clk, // System clock, 100 MHz
   input wire logic reset, // Async reset, active high
   input wire power_state_e power_state, // Chip power state
   input wire mode_write_s mode_write, // Mode control write
   input wire reload_write_s reload_write, // Reload value write
   input wire logic overflow_flag_clear, // Pulse: clear request flag
   input wire logic overflow_irq_enable, // Overflow interrupt enable
   output logic [7:0] count_value, // Current count
   output logic [7:0] reload_value, // Reload register readback
   output logic count_mode_select, // Mode bit readback
   output logic [2:0] clock_source_field, // Clock source readback
   output logic overflow_request_flag, // Sticky overflow flag
   output logic overflow_pulse, // One cycle per overflow
   output logic overflow_irq // Interrupt request to CPU
);

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [7:0] count;
      logic [7:0] reload;
      count_mode_e mode;
      logic [2:0] src;
      logic flag;
      logic ovf;
      logic irq;
   } timer_state_s;

   timer_state_s state_reg;
   timer_state_s state_next;

   logic [6:0] tap_tick;
   logic count_tick;
   logic running;
   logic at_max;
   logic overflow_event;

   // ****************************************
   // Prescaler
   // ****************************************
   timer_prescaler u_prescaler (
      .core_clk(core_clk),
      .reset(reset),
      .tap_tick(tap_tick)
   );

   // Source code 7 has no tap; the counter then stands still
   function automatic logic pick_tap(input logic [6:0] ticks, input logic [2:0] sel);
      logic hit;
      hit = 1'b0;
      if (sel < 3'h7) begin
         hit = ticks[sel];
      end
      return hit;
   endfunction

   // ****************************************
   // Count enable
   // ****************************************
   always_comb begin
      case (power_state)
         PWR_ACTIVE: running = 1'b1;
         PWR_SLEEP: running = 1'b1;
         PWR_SUBSLEEP: running = 1'b0;
         PWR_STANDBY: running = 1'b0;
         default: running = 1'b0;
      endcase
   end

   assign count_tick = running & pick_tap(tap_tick, state_reg.src);
   assign at_max = (state_reg.count == `TMR_COUNT_MAX);
   // A reload write in the same cycle wins over the tick, so no overflow then
   assign overflow_event = count_tick & at_max & ~reload_write.strobe;

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      state_next = state_reg;
      state_next.ovf = 1'b0;

      // Mode register only accepts writes in active state
      if (mode_write.strobe && (power_state == PWR_ACTIVE)) begin
         state_next.mode = mode_write.count_mode_select;
         state_next.src = mode_write.clock_source_field;
      end

      if (reload_write.strobe) begin
         state_next.reload = reload_write.value;
         // Both modes take the written value as the new start point
         state_next.count = reload_write.value;
      end else if (count_tick) begin
         if (at_max) begin
            state_next.ovf = 1'b1;
            case (state_reg.mode)
               MODE_INTERVAL: state_next.count = `TMR_COUNT_RST;
               MODE_AUTO_RELOAD: state_next.count = state_reg.reload;
               default: state_next.count = `TMR_COUNT_RST;
            endcase
         end else begin
            state_next.count = state_reg.count + 8'h01;
         end
      end

      // Set wins over a clear in the same cycle
      if (overflow_event) begin
         state_next.flag = 1'b1;
      end else if (overflow_flag_clear) begin
         state_next.flag = 1'b0;
      end

      state_next.irq = state_next.flag & overflow_irq_enable;
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state_reg.count <= `TMR_COUNT_RST;
         state_reg.reload <= `TMR_RELOAD_RST;
         state_reg.mode <= MODE_INTERVAL;
         state_reg.src <= `TMR_SRC_RST;
         state_reg.flag <= 1'b0;
         state_reg.ovf <= 1'b0;
         state_reg.irq <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign count_value = state_reg.count;
   assign reload_value = state_reg.reload;
   assign count_mode_select = state_reg.mode;
   assign clock_source_field = state_reg.src;
   assign overflow_request_flag = state_reg.flag;
   assign overflow_pulse = state_reg.ovf;
   assign overflow_irq = state_reg.irq;

endmodule // eight_bit_reload_interval_timer

// File: hdl/reload_timer_pkg.sv
package reload_timer_pkg;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      PWR_ACTIVE = 2'b00,
      PWR_SLEEP = 2'b01,
      PWR_SUBSLEEP = 2'b10,
      PWR_STANDBY = 2'b11
   } power_state_e;

   typedef enum logic {
      MODE_INTERVAL = 1'b0,
      MODE_AUTO_RELOAD = 1'b1
   } count_mode_e;

   typedef struct packed {
      logic strobe;
      count_mode_e count_mode_select;
      logic [2:0] clock_source_field;
   } mode_write_s;

   typedef struct packed {
      logic strobe;
      logic [7:0] value;
   } reload_write_s;

endpackage

// File: hdl/reload_timer_regs.svh
`ifndef RELOAD_TIMER_REGS_SVH
`define RELOAD_TIMER_REGS_SVH

// ****************************************
// Widths
// ****************************************
`define TMR_COUNT_W 8
`define TMR_SRC_W 3
`define TMR_TAP_N 7
`define TMR_PRESC_W 13

// ****************************************
// Reset values
// ****************************************
`define TMR_COUNT_RST 8'h00
`define TMR_RELOAD_RST 8'h00
`define TMR_MODE_RST 1'b0
`define TMR_SRC_RST 3'h0
`define TMR_COUNT_MAX 8'hff

// ****************************************
// Prescaler tap positions (tick every 2**(pos+1) clocks)
// ****************************************
`define TMR_TAP0_POS 12
`define TMR_TAP1_POS 10
`define TMR_TAP2_POS 8
`define TMR_TAP3_POS 7
`define TMR_TAP4_POS 6
`define TMR_TAP5_POS 4
`define TMR_TAP6_POS 2

`endif

// File: hdl/timer_prescaler.sv
`timescale 1ns/1ps
`include "reload_timer_regs.svh"

module timer_prescaler
   import reload_timer_pkg::*;
(
   input wire logic core_clk, // System clock
   input wire logic reset, // Async reset, active high
   output logic [6:0] tap_tick // One-cycle tick per tap
);

   typedef struct packed {
      logic [12:0] div;
      logic [6:0] tick;
   } presc_state_s;

   presc_state_s state_reg;
   presc_state_s state_next;

   // Tick when all bits up to the tap position are ones
   function automatic logic tap_hit(input logic [12:0] div, input int pos);
      logic hit;
      hit = 1'b1;
      for (int i = 0; i <= pos; i++) begin
         hit = hit & div[i];
      end
      return hit;
   endfunction

   always_comb begin
      state_next = state_reg;
      state_next.div = state_reg.div + 13'h0001;
      state_next.tick[0] = tap_hit(state_reg.div, `TMR_TAP0_POS);
      state_next.tick[1] = tap_hit(state_reg.div, `TMR_TAP1_POS);
      state_next.tick[2] = tap_hit(state_reg.div, `TMR_TAP2_POS);
      state_next.tick[3] = tap_hit(state_reg.div, `TMR_TAP3_POS);
      state_next.tick[4] = tap_hit(state_reg.div, `TMR_TAP4_POS);
      state_next.tick[5] = tap_hit(state_reg.div, `TMR_TAP5_POS);
      state_next.tick[6] = tap_hit(state_reg.div, `TMR_TAP6_POS);
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign tap_tick = state_reg.tick;

endmodule // timer_prescaler

// File: testbench/eight_bit_reload_interval_timer_tb_top.sv
`timescale 1ns/1ps
module eight_bit_reload_interval_timer_tb_top
   import reload_timer_pkg::*;
;
   // ****
   // Stimulus and checks
   // ****
   logic core_clk, reset, overflow_flag_clear, overflow_irq_enable;
   power_state_e power_state;
   mode_write_s mode_write;
   reload_write_s reload_write;
   logic [7:0] count_value, reload_value;
   logic count_mode_select, overflow_request_flag, overflow_pulse, overflow_irq;
   logic [2:0] clock_source_field;
   int err_total = 0, comparisons = 0, n;
   int pos[7] = '{12, 10, 8, 7, 6, 4, 2};
   eight_bit_reload_interval_timer dut (.*);
   initial begin
      core_clk = 0;
      forever #5 core_clk = ~core_clk;
   end
   task chk(logic [15:0] s, logic [15:0] e);
      comparisons++;
      if (s !== e) begin
         err_total++;
         $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
      end
   endtask
   task mw(logic m, logic [2:0] s);
      @(negedge core_clk) mode_write = '{1'b1, count_mode_e'(m), s};
      @(negedge core_clk) mode_write.strobe = 0;
   endtask
   task rw(logic [7:0] v);
      @(negedge core_clk) reload_write = '{1'b1, v};
      @(negedge core_clk) reload_write.strobe = 0;
   endtask
   // Wait on pulse, bounded so a dead counter cannot hang
   task per;
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (overflow_pulse !== 1'b1 && n < 9000);
   endtask
   task t_reset;
      chk({count_value, reload_value}, 16'h0000);
      chk({count_mode_select, clock_source_field, overflow_request_flag}, 0);
   endtask
   task t_auto;
      rw(8'hff);
      for (int k = 0; k < 7; k++) begin
         mw(1, k[2:0]);
         per;
         per;
         chk(n, 2 ** (pos[k] + 1));
         chk(count_value, 8'hff);
      end
      rw(8'h00);
      per;
      per;
      chk(n, 256 * 8);
   endtask
   task t_int;
      // Flag is still set from the auto-reload runs
      @(negedge core_clk) overflow_flag_clear = 1;
      @(negedge core_clk) overflow_flag_clear = 0;
      chk(overflow_request_flag, 0);
      mw(0, 3'h6);
      rw(8'hfd);
      chk(count_value, 8'hfd);
      overflow_irq_enable = 1;
      per;
      chk({count_value, overflow_request_flag, overflow_irq}, {8'h00, 2'b11});
      @(negedge core_clk) overflow_flag_clear = 1;
      @(negedge core_clk) overflow_flag_clear = 0;
      chk({overflow_request_flag, overflow_irq}, 0);
   endtask
   task t_pwr;
      overflow_irq_enable = 0;
      power_state = PWR_SUBSLEEP;
      mw(1, 3'h6);
      chk(count_mode_select, 0);
      n = count_value;
      repeat (40) @(negedge core_clk);
      chk(count_value, n[7:0]);
      power_state = PWR_SLEEP;
      per;
      chk({overflow_request_flag, overflow_irq}, 2'b10);
      power_state = PWR_ACTIVE;
      mw(0, 3'h7);
      n = count_value;
      repeat (40) @(negedge core_clk);
      chk(count_value, n[7:0]);
   endtask
   task test_done;
      $display("errors %0d of %0d checks", err_total, comparisons);
      if (err_total == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      {reset, overflow_flag_clear, overflow_irq_enable} = 3'b100;
      power_state = PWR_ACTIVE;
      mode_write = '0;
      reload_write = '0;
      repeat (8) @(negedge core_clk);
      reset = 0;
      t_reset;
      t_auto;
      t_int;
      t_pwr;
      test_done;
   end
   // Whole run is near 30k cycles
   initial begin
      #600000;
      err_total++;
      test_done;
   end
endmodule // eight_bit_reload_interval_timer_tb_top

// File: testbench/reload_timer_checker.sv
`timescale 1ns/1ps
// ****
// Port checks
// ****
module reload_timer_checker
   import reload_timer_pkg::*;
(
   input wire logic core_clk, // clk
   input wire logic reset, // rst
   input wire power_state_e power_state, // pwr
   input wire mode_write_s mode_write, // mode wr
   input wire reload_write_s reload_write, // rld wr
   input wire logic overflow_flag_clear, // clr
   input wire logic overflow_irq_enable, // ie
   input wire logic [7:0] count_value, // cnt
   input wire logic [7:0] reload_value, // rld
   input wire logic count_mode_select, // mode
   input wire logic [2:0] clock_source_field, // src
   input wire logic overflow_request_flag, // flag
   input wire logic overflow_pulse, // ovf
   input wire logic overflow_irq // irq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   a_pulse_from_max: assert property (overflow_pulse |-> $past(count_value) == 8'hff)
      else $error("overflow not from max");
   a_pulse_sets_flag: assert property (overflow_pulse |-> overflow_request_flag)
      else $error("flag not set");
   a_pulse_single: assert property (overflow_pulse |=> !overflow_pulse)
      else $error("pulse too long");
   a_wrap_zero: assert property (overflow_pulse && !$past(count_mode_select) |-> count_value == 8'h00)
      else $error("no wrap to zero");
   a_reload_copy: assert property (overflow_pulse && $past(count_mode_select) |-> count_value == reload_value)
      else $error("no reload copy");
   a_write_loads: assert property (reload_write.strobe |=> count_value == $past(reload_write.value)
      && reload_value == $past(reload_write.value))
      else $error("write not loaded");
   a_irq_gate: assert property (overflow_irq == (overflow_request_flag && $past(overflow_irq_enable)))
      else $error("irq gating wrong");
   a_count_step: assert property (!$past(reload_write.strobe) && count_value != $past(count_value)
      |-> count_value == $past(count_value) + 8'h01 || overflow_pulse)
      else $error("bad count step");
   a_halt_low: assert property (power_state[1] && !reload_write.strobe |=> $stable(count_value))
      else $error("counted while halted");
   a_mode_kept: assert property (mode_write.strobe && power_state != PWR_ACTIVE |=> $stable(count_mode_select))
      else $error("mode written off active");
   a_flag_sticky: assert property ($fell(overflow_request_flag) |-> $past(overflow_flag_clear))
      else $error("flag dropped alone");
endmodule // reload_timer_checker
bind eight_bit_reload_interval_timer reload_timer_checker chk (.*);
